// *** logic/tcd_top.sv ***
// Event-triggered transfer controller with descriptor registers.
//
// Operation
// (RQ1) Enable bit gates trigger; end event clears it.
// (RQ2) Size field: 0 moves bytes, 1 moves halfwords.
// (RQ3) Repeat interrupt enable, ignored in normal mode.
// (RQ4) Chain continues next descriptor; none past 23.
// (RQ5) Destination fixed or stepping; repeat area steps.
// (RQ6) Source fixed or stepping; repeat area steps.
// (RQ7) Area select picks repeat side; normal ignores it.
// (RQ8) Mode bit: 0 normal, 1 repeat.
// (RQ9) Block size N units, 00H means 256.
// (RQ10) Transfer count N blocks, 00H means 256.
// (RQ11) Software programs 16-bit source and destination.
// (RQ12) Base gives area high byte; repeat reloads count.
`timescale 1ns/1ns
`include "tcd_defines.svh"

module tcd_top
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Avalon-MM register slave.
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Activation sources and interrupt.
	input wire logic [7:0] i_trig,
	output logic o_irq,
	output logic o_busy,
	// System memory.
	output tcd_pkg::tcd_mem_s o_mem,
	input wire logic [15:0] i_mem_rdata,
	input wire logic i_mem_ready
);
	import tcd_pkg::*;

	tcd_top_s r_reg;
	tcd_top_s r_next;
	tcd_bans_s ans;

	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// A count field of zero stands for a full 256.
	function automatic logic [8:0] units_of(input logic [7:0] v);
		units_of = (v == 8'h00) ? `TCD_FULL_COUNT : {1'b0, v};
	endfunction : units_of

	// Merge one written byte lane into a stored byte.
	function automatic logic [7:0] lane8(input logic [7:0] old,
		input logic [7:0] wd, input logic be);
		lane8 = be ? wd : old;
	endfunction : lane8

	// Address of one 16-bit word of a descriptor in the area.
	function automatic logic [15:0] desc_addr(input logic [7:0] base,
		input logic [4:0] idx, input logic [1:0] word);
		desc_addr = {base, idx, word, 1'b0};
	endfunction : desc_addr

	function automatic tcd_breq_s mk_req(input logic wr,
		input logic wide, input logic [15:0] addr,
		input logic [15:0] wdata);
		mk_req = '{req: 1'b1, write: wr, wide: wide, addr: addr,
			wdata: wdata};
	endfunction : mk_req

	// Lowest pending source wins when several wait.
	function automatic logic [2:0] lowest(input logic [7:0] p);
		lowest = 3'h0;
		for (int i = 7; i >= 0; i--)
			if (p[i])
				lowest = 3'(i);
	endfunction : lowest

	// Register read multiplexer.
	function automatic logic [31:0] rd_mux(input tcd_top_s s,
		input logic [3:0] a);
		case (a)
			`TCD_REG_ENABLE: rd_mux = {24'h0, s.enable};
			`TCD_REG_BASE: rd_mux = {24'h0, s.base};
			`TCD_REG_CTL0: rd_mux = {24'h0, 1'b0, s.d0.ctl[6:0]};
			`TCD_REG_BLS0: rd_mux = {24'h0, s.d0.bls};
			`TCD_REG_CCT0: rd_mux = {24'h0, s.d0.cct};
			`TCD_REG_RLD0: rd_mux = {24'h0, s.d0.rld};
			`TCD_REG_SAR0: rd_mux = {16'h0, s.d0.sar};
			`TCD_REG_DAR0: rd_mux = {16'h0, s.d0.dar};
			`TCD_REG_STATUS: rd_mux = {24'h0, s.status};
			`TCD_REG_MASK: rd_mux = {24'h0, s.mask};
			`TCD_REG_STATE: rd_mux = {24'h0, s.busy, 2'b0, s.didx};
			default: rd_mux = 32'h0;
		endcase
	endfunction : rd_mux

	// ------------------------------------------------------------
	// Bus port toward memory
	// ------------------------------------------------------------

	tcd_busport u_port
	(
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_req(r_reg.breq),
		.o_ans(ans),
		.o_mem(o_mem),
		.i_mem_rdata(i_mem_rdata),
		.i_mem_ready(i_mem_ready)
	);

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	logic [7:0] rise;
	logic [2:0] pick;
	logic rpt;
	logic area_src;
	logic wide;
	logic [15:0] inc;
	logic [15:0] span;
	logic [31:0] wd;
	logic [3:0] be;

	// Registers, trigger capture and the transfer engine in one pass.
	// Order matters: software effects first, hardware effects last,
	// so a hardware set or clear in the same cycle is never lost.
	always_comb
	begin
		r_next = r_reg;
		r_next.breq.req = 1'b0;
		wd = i_avs_writedata;
		be = i_avs_byteenable;
		rpt = r_reg.cur.ctl[`TCD_CTL_REPEAT_MODE]; // [RQ8]
		area_src = r_reg.cur.ctl[`TCD_CTL_AREA_SEL] & rpt; // [RQ7]
		wide = r_reg.cur.ctl[`TCD_CTL_UNIT_SIZE]; // [RQ2]
		inc = wide ? 16'h0002 : 16'h0001; // [RQ2]
		span = 16'(units_of(r_reg.cur.rld) * units_of(r_reg.cur.bls)
			* 18'(inc[1:0]));
		pick = lowest(r_reg.pend);

		// Three-stage capture; a rising edge counts once stages two
		// and three agree high while the last level was low.
		r_next.sync1 = i_trig;
		r_next.sync2 = r_reg.sync1;
		r_next.sync3 = r_reg.sync2;
		rise = r_reg.sync2 & r_reg.sync3 & ~r_reg.level;
		for (int i = 0; i < 8; i++)
			if (r_reg.sync2[i] == r_reg.sync3[i])
				r_next.level[i] = r_reg.sync2[i];

		// Avalon slave: one wait cycle, then the access completes.
		r_next.waitreq = 1'b1;
		if ((i_avs_read | i_avs_write) & r_reg.waitreq)
		begin
			r_next.waitreq = 1'b0;
			r_next.rdata = rd_mux(r_reg, i_avs_address);
		end
		if (i_avs_read & ~r_reg.waitreq &
			(i_avs_address == `TCD_REG_STATUS))
			r_next.status = r_reg.status & ~r_reg.rdata[7:0];
		if (i_avs_write & ~r_reg.waitreq)
		begin
			case (i_avs_address)
				`TCD_REG_ENABLE:
					r_next.enable = lane8(r_reg.enable, wd[7:0], be[0]);
				`TCD_REG_BASE:
					r_next.base = lane8(r_reg.base, wd[7:0], be[0]); // [RQ12]
				`TCD_REG_CTL0:
					r_next.d0.ctl = lane8(r_reg.d0.ctl, {1'b0, wd[6:0]},
						be[0]);
				`TCD_REG_BLS0:
					r_next.d0.bls = lane8(r_reg.d0.bls, wd[7:0], be[0]);
				`TCD_REG_CCT0:
					r_next.d0.cct = lane8(r_reg.d0.cct, wd[7:0], be[0]);
				`TCD_REG_RLD0:
					r_next.d0.rld = lane8(r_reg.d0.rld, wd[7:0], be[0]);
				`TCD_REG_SAR0:
					r_next.d0.sar = {lane8(r_reg.d0.sar[15:8], wd[15:8],
						be[1]), lane8(r_reg.d0.sar[7:0], wd[7:0], be[0])};
				`TCD_REG_DAR0:
					r_next.d0.dar = {lane8(r_reg.d0.dar[15:8], wd[15:8],
						be[1]), lane8(r_reg.d0.dar[7:0], wd[7:0], be[0])};
				`TCD_REG_MASK:
					r_next.mask = lane8(r_reg.mask, wd[7:0], be[0]);
				default:
					r_next.mask = r_next.mask; // Unmapped writes drop.
			endcase
		end

		// Trigger is taken only while its enable bit is set.
		r_next.pend = r_reg.pend | (rise & r_reg.enable); // [RQ1]

		// Transfer engine.
		unique case (r_reg.state)
			ST_IDLE:
				if (r_reg.pend != 8'h00)
				begin
					r_next.pend[pick] = 1'b0;
					r_next.src = pick;
					r_next.didx = {2'b00, pick};
					r_next.endev = 1'b0;
					if (pick == 3'h0)
					begin
						r_next.cur = r_reg.d0;
						r_next.units = units_of(r_reg.d0.bls); // [RQ9]
						r_next.state = ST_READ;
						r_next.breq = mk_req(1'b0,
							r_reg.d0.ctl[`TCD_CTL_UNIT_SIZE], r_reg.d0.sar,
							`TCD_RST_WORD);
					end
					else
					begin
						r_next.step = `TCD_WORD_CTL;
						r_next.state = ST_FETCH;
						r_next.breq = mk_req(1'b0, 1'b1, desc_addr(r_reg.base,
							{2'b00, pick}, `TCD_WORD_CTL), `TCD_RST_WORD); // [RQ12]
					end
				end
			ST_FETCH:
				if (ans.done)
				begin
					unique case (r_reg.step)
						`TCD_WORD_CTL:
							{r_next.cur.bls, r_next.cur.ctl} = ans.rdata;
						`TCD_WORD_CNT:
							{r_next.cur.rld, r_next.cur.cct} = ans.rdata;
						`TCD_WORD_SRC: r_next.cur.sar = ans.rdata;
						`TCD_WORD_DST: r_next.cur.dar = ans.rdata;
					endcase
					if (r_reg.step == `TCD_WORD_DST)
					begin
						r_next.units = units_of(r_reg.cur.bls); // [RQ9]
						r_next.state = ST_READ;
						r_next.breq = mk_req(1'b0, wide, r_reg.cur.sar,
							`TCD_RST_WORD);
					end
					else
					begin
						r_next.step = r_reg.step + 2'h1;
						r_next.breq = mk_req(1'b0, 1'b1, desc_addr(r_reg.base,
							r_reg.didx, r_reg.step + 2'h1), `TCD_RST_WORD);
					end
				end
			ST_READ:
				if (ans.done)
				begin
					r_next.state = ST_WRITE;
					r_next.breq = mk_req(1'b1, wide, r_reg.cur.dar,
						ans.rdata);
				end
			ST_WRITE:
				if (ans.done)
				begin
					// The repeat area always steps; the other side obeys
					// its own step bit.
					if (r_reg.cur.ctl[`TCD_CTL_SRC_STEP] | area_src) // [RQ6]
						r_next.cur.sar = r_reg.cur.sar + inc;
					if (r_reg.cur.ctl[`TCD_CTL_DST_STEP] & ~(rpt & ~area_src)
						| (rpt & ~area_src)) // [RQ5]
						r_next.cur.dar = r_reg.cur.dar + inc;
					r_next.units = r_reg.units - 9'h001;
					if (r_reg.units == 9'h001)
					begin
						r_next.cur.cct = r_reg.cur.cct - 8'h01; // [RQ10]
						if (r_reg.cur.cct == 8'h01)
						begin
							if (rpt)
							begin
								// Reload and rewind the repeat area.
								r_next.cur.cct = r_reg.cur.rld; // [RQ12]
								if (area_src)
									r_next.cur.sar = r_next.cur.sar - span;
								else
									r_next.cur.dar = r_next.cur.dar - span;
								r_next.endev =
									r_reg.cur.ctl[`TCD_CTL_RPT_IRQ]; // [RQ3]
							end
							else
								r_next.endev = 1'b1; // [RQ3]
						end
						if (r_reg.didx == 5'h00)
						begin
							r_next.d0 = r_next.cur;
							r_next.state = ST_NEXT;
						end
						else
						begin
							r_next.step = `TCD_WORD_CNT;
							r_next.state = ST_WBACK;
							r_next.breq = mk_req(1'b1, 1'b1, desc_addr(r_reg.base,
								r_reg.didx, `TCD_WORD_CNT),
								{r_next.cur.rld, r_next.cur.cct});
						end
					end
					else
					begin
						r_next.state = ST_READ;
						r_next.breq = mk_req(1'b0, wide, r_next.cur.sar,
							`TCD_RST_WORD);
					end
				end
			ST_WBACK:
				if (ans.done)
				begin
					if (r_reg.step == `TCD_WORD_DST)
						r_next.state = ST_NEXT;
					else
					begin
						r_next.step = r_reg.step + 2'h1;
						r_next.breq = mk_req(1'b1, 1'b1, desc_addr(r_reg.base,
							r_reg.didx, r_reg.step + 2'h1),
							(r_reg.step == `TCD_WORD_CNT) ? r_reg.cur.sar :
							r_reg.cur.dar);
					end
				end
			ST_NEXT:
			begin
				if (r_reg.endev)
				begin
					r_next.status[r_reg.src] = 1'b1;
					r_next.enable[r_reg.src] = 1'b0; // [RQ1]
				end
				r_next.endev = 1'b0;
				// Descriptor 23 never chains, whatever its bit says.
				if (r_reg.cur.ctl[`TCD_CTL_CHAIN] &
					(r_reg.didx != `TCD_LAST_DESC)) // [RQ4]
				begin
					r_next.didx = r_reg.didx + 5'h01;
					r_next.step = `TCD_WORD_CTL;
					r_next.state = ST_FETCH;
					r_next.breq = mk_req(1'b0, 1'b1, desc_addr(r_reg.base,
						r_reg.didx + 5'h01, `TCD_WORD_CTL), `TCD_RST_WORD);
				end
				else
					r_next.state = ST_IDLE;
			end
			default:
				r_next.state = ST_IDLE;
		endcase

		r_next.busy = (r_next.state != ST_IDLE);
		r_next.irq = |(r_next.status & r_next.mask);
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Waitrequest idles high so an access never completes by accident.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
		begin
			r_reg <= '0;
			r_reg.waitreq <= 1'b1;
		end
		else
			r_reg <= r_next;
	end

	assign o_avs_readdata = r_reg.rdata;
	assign o_avs_waitrequest = r_reg.waitreq;
	assign o_irq = r_reg.irq;
	assign o_busy = r_reg.busy;

endmodule : tcd_top

// *** include/tcd_defines.svh ***
// Offsets, field positions, reset values and limits of the transfer block.
`ifndef TCD_DEFINES_SVH
`define TCD_DEFINES_SVH

// ------------------------------------------------------------
// Register word indices (byte address is four times the index)
// ------------------------------------------------------------
`define TCD_REG_ENABLE 4'h0
`define TCD_REG_BASE 4'h1
`define TCD_REG_CTL0 4'h2
`define TCD_REG_BLS0 4'h3
`define TCD_REG_CCT0 4'h4
`define TCD_REG_RLD0 4'h5
`define TCD_REG_SAR0 4'h6
`define TCD_REG_DAR0 4'h7
`define TCD_REG_STATUS 4'h8
`define TCD_REG_MASK 4'h9
`define TCD_REG_STATE 4'ha

// ------------------------------------------------------------
// Control word field positions
// ------------------------------------------------------------
`define TCD_CTL_REPEAT_MODE 0
`define TCD_CTL_AREA_SEL 1
`define TCD_CTL_SRC_STEP 2
`define TCD_CTL_DST_STEP 3
`define TCD_CTL_CHAIN 4
`define TCD_CTL_RPT_IRQ 5
`define TCD_CTL_UNIT_SIZE 6

// ------------------------------------------------------------
// Reset values and descriptor area layout
// ------------------------------------------------------------
`define TCD_RST_BYTE 8'h00
`define TCD_RST_WORD 16'h0000
`define TCD_WORD_CTL 2'h0
`define TCD_WORD_CNT 2'h1
`define TCD_WORD_SRC 2'h2
`define TCD_WORD_DST 2'h3
`define TCD_LAST_DESC 5'h17
`define TCD_FULL_COUNT 9'h100

`endif

// *** include/tcd_pkg.sv ***
// Types shared by the transfer block and its system bus port.
package tcd_pkg;

	// Engine states, Gray coded along fetch, read, write, write-back.
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_FETCH = 3'h1,
		ST_READ = 3'h3,
		ST_WRITE = 3'h2,
		ST_WBACK = 3'h6,
		ST_NEXT = 3'h7
	} tcd_state_e;

	// One descriptor as held in registers and in the descriptor area.
	typedef struct packed
	{
		logic [7:0] ctl;
		logic [7:0] bls;
		logic [7:0] cct;
		logic [7:0] rld;
		logic [15:0] sar;
		logic [15:0] dar;
	} tcd_desc_s;

	// Request from the engine to the bus port.
	typedef struct packed
	{
		logic req;
		logic write;
		logic wide;
		logic [15:0] addr;
		logic [15:0] wdata;
	} tcd_breq_s;

	// Signals driven toward system memory.
	typedef struct packed
	{
		logic rd;
		logic wr;
		logic wide;
		logic [15:0] addr;
		logic [15:0] wdata;
	} tcd_mem_s;

	// Answer from the bus port.
	typedef struct packed
	{
		logic done;
		logic [15:0] rdata;
	} tcd_bans_s;

	typedef struct packed
	{
		tcd_mem_s mem;
		tcd_bans_s ans;
	} tcd_port_s;

	// Whole state of the top module.
	typedef struct packed
	{
		logic [7:0] enable;
		logic [7:0] base;
		tcd_desc_s d0;
		logic [7:0] status;
		logic [7:0] mask;
		logic irq;
		logic busy;
		logic waitreq;
		logic [31:0] rdata;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] level;
		logic [7:0] pend;
		tcd_state_e state;
		logic [2:0] src;
		logic [4:0] didx;
		logic [1:0] step;
		logic endev;
		logic [8:0] units;
		tcd_desc_s cur;
		tcd_breq_s breq;
	} tcd_top_s;

endpackage : tcd_pkg

// *** logic/tcd_busport.sv ***
// System bus port: one read or write at a time toward memory.
`timescale 1ns/1ns
`include "tcd_defines.svh"

module tcd_busport
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Engine side.
	input wire tcd_pkg::tcd_breq_s i_req,
	output tcd_pkg::tcd_bans_s o_ans,
	// Memory side.
	output tcd_pkg::tcd_mem_s o_mem,
	input wire logic [15:0] i_mem_rdata,
	input wire logic i_mem_ready
);
	import tcd_pkg::*;

	tcd_port_s r_reg;
	tcd_port_s r_next;

	// ------------------------------------------------------------
	// Access sequencing
	// ------------------------------------------------------------

	// A request is held on the memory pins until ready; a byte access
	// returns zero in the upper half so the engine sees clean data.
	always_comb
	begin
		r_next = r_reg;
		r_next.ans.done = 1'b0;
		if (r_reg.mem.rd | r_reg.mem.wr)
		begin
			if (i_mem_ready)
			begin
				r_next.mem.rd = 1'b0;
				r_next.mem.wr = 1'b0;
				r_next.ans.done = 1'b1;
				r_next.ans.rdata = r_reg.mem.wide ? i_mem_rdata :
					{8'h00, i_mem_rdata[7:0]};
			end
		end
		else if (i_req.req)
		begin
			r_next.mem.rd = ~i_req.write;
			r_next.mem.wr = i_req.write;
			r_next.mem.wide = i_req.wide;
			r_next.mem.addr = i_req.addr;
			r_next.mem.wdata = i_req.wide ? i_req.wdata :
				{8'h00, i_req.wdata[7:0]};
		end
	end

	// State register.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_rst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign o_mem = r_reg.mem;
	assign o_ans = r_reg.ans;

endmodule : tcd_busport

// *** bench/tcd_mem_model.sv ***
// Behavioural system memory that answers the transfer block.
`timescale 1ns/1ns

module tcd_mem_model
(
	// Clock and answer speed.
	input wire logic i_sys_clk,
	input wire logic i_slow,
	// Bus from the block.
	input wire tcd_pkg::tcd_mem_s i_mem,
	output logic [15:0] o_rdata,
	output logic o_ready
);
	import tcd_pkg::*;
	logic [7:0] mem [0:65535];
	logic [1:0] wait_cnt = 2'h0;
	logic ready_q = 1'b0;
	logic [15:0] rdata_q = 16'h0000;

	// Outputs start low so nothing completes before a request.
	assign o_ready = ready_q;
	assign o_rdata = rdata_q;

	// Answers after one or three cycles. Released data is inverted so a
	// stale value is never taken for a fresh one.
	always @(posedge i_sys_clk)
	begin
		if (ready_q || !(i_mem.rd || i_mem.wr))
		begin
			ready_q <= 1'b0;
			rdata_q <= ~rdata_q;
			wait_cnt <= 2'h0;
			if (ready_q && i_mem.wr)
			begin
				mem[i_mem.addr] <= i_mem.wdata[7:0];
				if (i_mem.wide)
					mem[i_mem.addr + 16'h0001] <= i_mem.wdata[15:8];
			end
		end
		else if (wait_cnt == {i_slow, 1'b0})
		begin
			ready_q <= 1'b1;
			rdata_q[7:0] <= mem[i_mem.addr];
			rdata_q[15:8] <= i_mem.wide ? mem[i_mem.addr + 16'h0001] : 8'h00;
		end
		else
			wait_cnt <= wait_cnt + 2'h1;
	end
endmodule : tcd_mem_model

// *** bench/tcd_top_assertions.sv ***
// Concurrent checks on the ports of the transfer block.
`timescale 1ns/1ns

module tcd_top_assertions
(
	// Clock and reset.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Register bus.
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [31:0] o_avs_readdata,
	input wire logic o_avs_waitrequest,
	// Interrupt and memory.
	input wire logic o_irq,
	input wire logic o_busy,
	input wire tcd_pkg::tcd_mem_s o_mem,
	input wire logic i_mem_ready
);
	import tcd_pkg::*;
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	// A register request meets a waiting slave, then a one-cycle answer.
	sequence s_taken;
		(i_avs_read || i_avs_write) && o_avs_waitrequest;
	endsequence
	sequence s_ack;
		!o_avs_waitrequest ##1 o_avs_waitrequest;
	endsequence
	sequence s_mem_done;
		(o_mem.rd || o_mem.wr) && i_mem_ready;
	endsequence

	chk_bus_answer: assert property (s_taken |=> s_ack)
		else $error("register access not answered after one wait cycle");
	chk_no_spur_ack: assert property (!(i_avs_read || i_avs_write)
		&& o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("answer without a request");
	chk_unmapped_zero: assert property (s_taken and (i_avs_read
		&& i_avs_address > 4'ha) |=> o_avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	chk_mask_quiet: assert property (i_avs_write && !o_avs_waitrequest
		&& i_avs_address == 4'h9 && i_avs_writedata[7:0] == 8'h00
		|-> ##2 !o_irq)
		else $error("interrupt high with all sources masked");
	chk_mem_excl: assert property (!(o_mem.rd && o_mem.wr))
		else $error("memory read and write together");
	chk_mem_hold: assert property ((o_mem.rd || o_mem.wr)
		&& !i_mem_ready |=> $stable(o_mem))
		else $error("memory request changed before acknowledge");
	chk_mem_gap: assert property (s_mem_done |=> !o_mem.rd && !o_mem.wr)
		else $error("memory request not released after acknowledge");
	chk_byte_lane: assert property (o_mem.wr && !o_mem.wide
		|-> o_mem.wdata[15:8] == 8'h00)
		else $error("byte write with upper lane set");
	chk_busy_mem: assert property (o_mem.rd || o_mem.wr |-> o_busy)
		else $error("memory access while idle");
endmodule : tcd_top_assertions

bind tcd_top tcd_top_assertions u_chk (.i_sys_clk, .i_rst, .i_avs_address,
	.i_avs_read, .i_avs_write, .i_avs_writedata, .o_avs_readdata,
	.o_avs_waitrequest, .o_irq, .o_busy, .o_mem, .i_mem_ready);

// *** bench/tcd_top_tb.sv ***
// Self-checking bench for the transfer block with a memory model.
`timescale 1ns/1ns
`include "tcd_defines.svh"

module tcd_top_tb;
	import tcd_pkg::*;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic [3:0] i_avs_address = 4'h0;
	logic i_avs_read = 1'b0;
	logic i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0] i_avs_byteenable = 4'h3;
	logic [31:0] o_avs_readdata;
	logic o_avs_waitrequest;
	logic [7:0] i_trig = 8'h00;
	logic o_irq;
	logic o_busy;
	tcd_mem_s o_mem;
	logic [15:0] i_mem_rdata;
	logic i_mem_ready;
	logic slow = 1'b0;
	logic [31:0] got;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	// Descriptors 1 and 2; the second ends the chain.
	logic [7:0] dtab [16] = '{8'h1c, 8'h01, 8'h01, 8'h00, 8'h00, 8'h10,
		8'h00, 8'h51, 8'h0c, 8'h01, 8'h01, 8'h00, 8'h04, 8'h10, 8'h00, 8'h52};

	tcd_top uut (.i_sys_clk, .i_rst, .i_avs_address, .i_avs_read,
		.i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
		.o_avs_waitrequest, .i_trig, .o_irq, .o_busy, .o_mem, .i_mem_rdata,
		.i_mem_ready);
	tcd_mem_model u_mem (.i_sys_clk, .i_slow(slow), .i_mem(o_mem),
		.o_rdata(i_mem_rdata), .o_ready(i_mem_ready));

	// 20 MHz clock.
	always #25 i_sys_clk = ~i_sys_clk;

	// A hang ends the run as a failure.
	always @(posedge i_sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			bad_count++;
			print_verdict();
		end
	end

	task check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		if (seen !== exp)
			bad_count++;
	endtask : check

	// One Avalon access, held until waitrequest is sampled low.
	task bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		i_avs_address <= a;
		i_avs_writedata <= {16'h0000, d};
		i_avs_read <= !w;
		i_avs_write <= w;
		do
			@(posedge i_sys_clk);
		while (o_avs_waitrequest !== 1'b0);
		got = o_avs_readdata;
		i_avs_read <= 1'b0;
		i_avs_write <= 1'b0;
		@(posedge i_sys_clk);
	endtask : bus

	task wreg(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask : wreg

	task rchk(input logic [3:0] a, input logic [15:0] e);
		bus(1'b0, a, 16'h0000);
		check(got, {16'h0000, e});
	endtask : rchk

	task mchk(input logic [15:0] a, input logic [7:0] e);
		check({24'h0, u_mem.mem[a]}, {24'h0, e});
	endtask : mchk

	task irq_chk(input logic e);
		repeat (2) @(posedge i_sys_clk);
		check({31'h0, o_irq}, {31'h0, e});
	endtask : irq_chk

	// Rising trigger, then wait until the engine is idle again.
	task fire(input int k);
		i_trig[k] <= 1'b1;
		repeat (12) @(posedge i_sys_clk);
		i_trig[k] <= 1'b0;
		while (o_busy !== 1'b0)
			@(posedge i_sys_clk);
		repeat (3) @(posedge i_sys_clk);
	endtask : fire

	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : print_verdict

	// Main sequence: reset, then one test per block of calls.
	initial
	begin
		for (int i = 0; i < 8; i++)
			u_mem.mem[16'h1000 + 16'(i)] = 8'h50 + 8'(i);
		for (int i = 0; i < 16; i++)
			u_mem.mem[16'h8008 + 16'(i)] = dtab[i];
		u_mem.mem[16'h2003] = 8'hee;
		repeat (2) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		@(posedge i_sys_clk);
		for (int i = 0; i < 12; i++)
			rchk(4'(i), 16'h0000);
		wreg(4'hb, 16'h00ff);
		rchk(4'hb, 16'h0000);
		$display("test reset done");
		wreg(`TCD_REG_SAR0, 16'h1000);
		wreg(`TCD_REG_DAR0, 16'h2000);
		wreg(`TCD_REG_BLS0, 16'h0003);
		wreg(`TCD_REG_CCT0, 16'h0001);
		wreg(`TCD_REG_CTL0, 16'h002e);
		wreg(`TCD_REG_MASK, 16'h0000);
		wreg(`TCD_REG_ENABLE, 16'h0001);
		fire(0);
		irq_chk(1'b0);
		wreg(`TCD_REG_MASK, 16'h0001);
		irq_chk(1'b1);
		for (int i = 0; i < 3; i++)
			mchk(16'h2000 + 16'(i), 8'h50 + 8'(i));
		rchk(`TCD_REG_ENABLE, 16'h0000);
		rchk(`TCD_REG_CCT0, 16'h0000);
		rchk(`TCD_REG_SAR0, 16'h1003);
		rchk(`TCD_REG_DAR0, 16'h2003);
		rchk(`TCD_REG_STATUS, 16'h0001);
		rchk(`TCD_REG_STATUS, 16'h0000);
		irq_chk(1'b0);
		fire(0);
		rchk(`TCD_REG_STATUS, 16'h0000);
		mchk(16'h2003, 8'hee);
		$display("test normal bytes done");
		wreg(`TCD_REG_DAR0, 16'h3000);
		wreg(`TCD_REG_SAR0, 16'h1000);
		wreg(`TCD_REG_BLS0, 16'h0002);
		wreg(`TCD_REG_CCT0, 16'h0002);
		wreg(`TCD_REG_CTL0, 16'h0044);
		wreg(`TCD_REG_ENABLE, 16'h0001);
		fire(0);
		rchk(`TCD_REG_CCT0, 16'h0001);
		rchk(`TCD_REG_ENABLE, 16'h0001);
		rchk(`TCD_REG_SAR0, 16'h1004);
		rchk(`TCD_REG_DAR0, 16'h3000);
		mchk(16'h3000, 8'h52);
		mchk(16'h3001, 8'h53);
		fire(0);
		rchk(`TCD_REG_STATUS, 16'h0001);
		mchk(16'h3000, 8'h56);
		mchk(16'h3001, 8'h57);
		$display("test halfwords done");
		wreg(`TCD_REG_SAR0, 16'h1000);
		wreg(`TCD_REG_DAR0, 16'h4000);
		wreg(`TCD_REG_BLS0, 16'h0001);
		wreg(`TCD_REG_CCT0, 16'h0001);
		wreg(`TCD_REG_RLD0, 16'h0001);
		wreg(`TCD_REG_CTL0, 16'h0001);
		wreg(`TCD_REG_ENABLE, 16'h0001);
		fire(0);
		mchk(16'h4000, 8'h50);
		rchk(`TCD_REG_DAR0, 16'h4000);
		rchk(`TCD_REG_CCT0, 16'h0001);
		rchk(`TCD_REG_SAR0, 16'h1000);
		rchk(`TCD_REG_STATUS, 16'h0000);
		rchk(`TCD_REG_ENABLE, 16'h0001);
		wreg(`TCD_REG_CTL0, 16'h002b);
		fire(0);
		rchk(`TCD_REG_STATUS, 16'h0001);
		rchk(`TCD_REG_ENABLE, 16'h0000);
		rchk(`TCD_REG_SAR0, 16'h1000);
		rchk(`TCD_REG_DAR0, 16'h4001);
		$display("test repeat done");
		wreg(`TCD_REG_SAR0, 16'h1000);
		wreg(`TCD_REG_DAR0, 16'h6000);
		wreg(`TCD_REG_BLS0, 16'h0000);
		wreg(`TCD_REG_CCT0, 16'h0000);
		wreg(`TCD_REG_CTL0, 16'h0008);
		wreg(`TCD_REG_ENABLE, 16'h0001);
		fire(0);
		mchk(16'h60ff, 8'h50);
		rchk(`TCD_REG_DAR0, 16'h6100);
		rchk(`TCD_REG_CCT0, 16'h00ff);
		rchk(`TCD_REG_STATUS, 16'h0000);
		rchk(`TCD_REG_ENABLE, 16'h0001);
		$display("test full counts done");
		slow <= 1'b1;
		wreg(`TCD_REG_BASE, 16'h0080);
		wreg(`TCD_REG_ENABLE, 16'h0002);
		fire(1);
		mchk(16'h5100, 8'h50);
		mchk(16'h5200, 8'h54);
		rchk(`TCD_REG_STATUS, 16'h0002);
		rchk(`TCD_REG_ENABLE, 16'h0000);
		mchk(16'h800a, 8'h00);
		rchk(`TCD_REG_STATE, 16'h0002);
		$display("test chain done");
		print_verdict();
	end
endmodule : tcd_top_tb
